/* File: bprs_pkg.sv */
// constants, state codes and register map for the board power and reset sequencer
package bprs_pkg;
  // clock rate and wait times
  localparam int CLK_MHZ = 125;
  localparam int CLK_KHZ = 125000;
  localparam int WAIT_LONG_MS = 10;
  localparam int WAIT_RAIL_MS = 5;
  localparam int WAIT_CLK_MS = 1;
  localparam int FLASH_MS = 500;
  localparam int CYC_LONG = WAIT_LONG_MS * CLK_KHZ;
  localparam int CYC_RAIL = WAIT_RAIL_MS * CLK_KHZ;
  localparam int CYC_CLK = WAIT_CLK_MS * CLK_KHZ;
  localparam int CYC_FLASH = FLASH_MS * CLK_KHZ;
  // sync pulse is a least width, so round up
  localparam int SYNC_PULSE_NS = 362;
  localparam logic [5:0] SYNC_PULSE_CYC = 6'((SYNC_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam int PPS_STABLE_US = 10;
  localparam logic [10:0] PPS_STABLE_CYC = 11'(PPS_STABLE_US * CLK_MHZ);
  // register map, byte offsets on the spi link
  localparam logic [6:0] REG_USER_LED = 7'h08;
  localparam logic [6:0] REG_REFCLK_SEL = 7'h09;
  localparam logic [6:0] REG_SEQ_STATE = 7'h0a;
  localparam logic [6:0] REG_LATCHED_GOOD = 7'h0b;
  localparam logic [3:0] USER_LED_RST = 4'h0;
  localparam logic REFCLK_SEL_RST = 1'b0;
  // spi frame: command byte (bit7 read, bits6:0 offset) then data byte
  localparam logic [4:0] SPI_CMD_LAST = 5'h07;
  localparam logic [4:0] SPI_DATA_LAST = 5'h0f;
  localparam int STRAP_W = 17;
  localparam int ASYNC_W = 35;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_EN5 = 4'h1,
    ST_EN25 = 4'h2,
    ST_CORE = 4'h3,
    ST_V18 = 4'h4,
    ST_CLK23 = 4'h5,
    ST_CLK1 = 4'h6,
    ST_V15 = 4'h7,
    ST_V075 = 4'h8,
    ST_RSTREL = 4'h9,
    ST_PORREL = 4'ha,
    ST_FULLREL = 4'hb,
    ST_ON = 4'hc,
    ST_FWAIT = 4'hd,
    ST_FAIL = 4'he
  } bprs_state_t;
endpackage

/* File: bprs_timer.sv */
// wait timer for the sequencer steps
`timescale 1ns/10ps
`default_nettype none
module bprs_timer
  import bprs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic run,
  input wire logic [31:0] limit,
  output logic done
);
  logic [31:0] count;
  logic [31:0] next_count;

  // counts up to the limit and parks there until cleared
  always_comb begin
    next_count = count;
    if (clear)
      next_count = 32'h0000_0000;
    else if (run && (count != limit))
      next_count = count + 32'h0000_0001;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      count <= 32'h0000_0000;
    else
      count <= next_count;
  end

  assign done = (count == limit);
endmodule
`default_nettype wire

/* File: bprs_top.sv */
// board power, clock and processor reset sequencer with spi register access
`timescale 1ns/10ps
`default_nettype none
module bprs_top
  import bprs_pkg::*;
#(
  parameter logic [31:0] P_WAIT_LONG = 32'(CYC_LONG),
  parameter logic [31:0] P_WAIT_RAIL = 32'(CYC_RAIL),
  parameter logic [31:0] P_WAIT_CLK = 32'(CYC_CLK),
  parameter logic [31:0] P_FLASH = 32'(CYC_FLASH),
  parameter logic [31:0] P_SYNC_MATCH = 32'h0000_1000
)(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic aux_rail_good,
  input wire logic five_volt_good,
  input wire logic two_five_volt_good,
  input wire logic core_supply_good_a,
  input wire logic core_supply_good_b,
  input wire logic core_supply_good_both,
  input wire logic one_eight_volt_good,
  input wire logic one_five_volt_good,
  input wire logic point75_volt_good,
  input wire logic clkgen23_locked,
  input wire logic clkgen1_locked,
  input wire logic proc_reset_status_n,
  input wire logic [STRAP_W-1:0] boot_strap_switches,
  input wire logic pcie_enable_switch,
  input wire logic refclk_default_switch,
  input wire logic pps_in,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic five_volt_enable,
  output logic two_five_volt_enable,
  output logic core_supply_enable_a,
  output logic core_supply_enable_b,
  output logic one_eight_volt_enable,
  output logic one_five_volt_enable,
  output logic point75_volt_enable,
  output logic level_shift_oe_n,
  output logic clkgen23_init,
  output logic clkgen1_init,
  output logic clkgen_power_down_n,
  output logic refclk_init,
  output logic refclk_buffer_oe,
  output logic refclk_source_select,
  output logic proc_reset_n,
  output logic proc_local_reset_n,
  output logic proc_power_on_reset_n,
  output logic proc_full_reset_n,
  output logic [STRAP_W-1:0] boot_strap_out,
  output logic [STRAP_W-1:0] boot_strap_oe_n,
  output logic proc_timer_in0_out,
  output logic proc_timer_in0_oe_n,
  output logic proc_timer_in1_out,
  output logic proc_timer_in1_oe_n,
  output logic rx_bandwidth_select,
  output logic power_good_led,
  output logic [3:0] debug_led,
  output logic proc_sync_pulse,
  output logic pps_forward_irq
);
  logic [ASYNC_W-1:0] sync1, sync2;
  logic [STRAP_W-1:0] s_strap;
  logic s_aux, s_five, s_two_five, s_ca, s_cb, s_cboth, s_one_eight, s_one_five, s_p75;
  logic s_lk23, s_lk1, s_status_n, s_pcie_en, s_refsw, s_pps, s_sck, s_cs_n, s_mosi;
  bprs_state_t state, next_state;
  logic seen, next_seen, cond, timer_clear, timer_done;
  logic [31:0] limit;
  logic status_prev, status_rise, rail_fail, all_good;
  logic strap_drv, next_strap_drv;
  logic [7:0] live_goods, latched_good, next_latched_good;
  logic flash_on, next_flash_on;
  logic [1:0] pair_idx, next_pair_idx;
  logic [3:0] user_led, next_user_led, next_debug_led;
  logic next_refsel, next_refclk_oe;
  logic sck_prev, sck_fall, sck_rise, spi_wr, next_miso;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift_in, next_shift_in, cmd, next_cmd, shift_out, next_shift_out, wr_data;
  logic [31:0] free_cnt;
  logic [5:0] sync_cnt, next_sync_cnt;
  logic [10:0] pps_cnt, next_pps_cnt;

  // register file read decode
  function automatic logic [7:0] reg_read(input logic [6:0] addr, input logic [3:0] led, input logic sel,
                                          input logic [3:0] st, input logic [7:0] goods);
    case (addr)
      REG_USER_LED: reg_read = {4'h0, led};
      REG_REFCLK_SEL: reg_read = {7'h00, sel};
      REG_SEQ_STATE: reg_read = {4'h0, st};
      REG_LATCHED_GOOD: reg_read = goods;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // every pin input except sys_clk and rstn goes through two flops; only sync2 is read by logic
  assign {s_strap, s_aux, s_five, s_two_five, s_ca, s_cb, s_cboth, s_one_eight, s_one_five, s_p75,
          s_lk23, s_lk1, s_status_n, s_pcie_en, s_refsw, s_pps, s_sck, s_cs_n, s_mosi} = sync2;
  assign all_good = s_aux & s_five & s_two_five & s_ca & s_cb & s_cboth & s_one_eight & s_one_five & s_p75;
  assign rail_fail = !all_good;
  assign status_rise = s_status_n & !status_prev;
  assign live_goods = {s_five, s_two_five, s_one_eight, s_one_five, s_p75, s_cboth, s_cb, s_ca};
  assign sck_fall = sck_prev & !s_sck;
  assign sck_rise = !sck_prev & s_sck;

  // sequencer steps; each timed step names its qualifying condition, and its wait when that is not the rail wait
  always_comb begin
    next_state = state;
    cond = 1'b0;
    limit = P_WAIT_RAIL;
    case (state)
      ST_IDLE: if (s_aux) next_state = ST_EN5;
      ST_EN5: begin
        cond = 1'b1;
        limit = P_WAIT_LONG;
        if (timer_done) next_state = ST_EN25;
      end
      ST_EN25: begin
        cond = s_five & s_two_five;
        if (timer_done) next_state = ST_CORE;
      end
      ST_CORE: begin
        cond = s_ca & s_cb;
        if (timer_done) next_state = ST_V18;
      end
      ST_V18: begin
        cond = s_one_eight;
        if (timer_done) next_state = ST_CLK23;
      end
      ST_CLK23: begin
        cond = s_lk23;
        limit = P_WAIT_CLK;
        if (timer_done) next_state = ST_CLK1;
      end
      ST_CLK1: begin
        cond = 1'b1;
        limit = P_WAIT_CLK;
        if (timer_done) next_state = ST_V15;
      end
      ST_V15: begin
        cond = s_one_five;
        if (timer_done) next_state = ST_V075;
      end
      ST_V075: begin
        cond = s_p75;
        if (timer_done) next_state = ST_RSTREL;
      end
      ST_RSTREL: begin
        cond = 1'b1;
        if (timer_done) next_state = ST_PORREL;
      end
      ST_PORREL: begin
        cond = 1'b1;
        if (timer_done) next_state = ST_FULLREL;
      end
      ST_FULLREL: if (status_rise) next_state = ST_ON;
      ST_ON: if (rail_fail) next_state = ST_FWAIT;
      ST_FWAIT: begin
        cond = 1'b1;
        if (timer_done) next_state = ST_FAIL;
      end
      ST_FAIL: begin
        cond = 1'b1;
        limit = P_FLASH;
      end
      default: next_state = ST_IDLE;
    endcase
    // a wait starts at first sight of its condition and keeps counting after that
    next_seen = (next_state != state) ? 1'b0 : (seen | cond);
    timer_clear = (next_state != state) || ((state == ST_FAIL) && timer_done);
  end

  bprs_timer u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clear(timer_clear),
    .run(cond | seen),
    .limit(limit),
    .done(timer_done)
  );

  // strap drive, latched goods, failure flashing and the spi register side
  always_comb begin
    next_strap_drv = strap_drv;
    if ((state == ST_V075) && s_p75)
      next_strap_drv = 1'b1;
    else if (((state == ST_FULLREL) && status_rise) || (state == ST_FAIL))
      next_strap_drv = 1'b0;
    // keep the last all-good snapshot; the failing sample itself is not stored
    next_latched_good = ((state == ST_ON) && !rail_fail) ? live_goods : latched_good;
    next_flash_on = flash_on;
    next_pair_idx = pair_idx;
    if ((state == ST_FAIL) && timer_done) begin
      next_flash_on = !flash_on;
      if (flash_on) next_pair_idx = pair_idx + 2'h1;
    end
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_cmd = cmd;
    next_shift_out = shift_out;
    next_miso = spi_miso;
    spi_wr = 1'b0;
    wr_data = {shift_in[6:0], s_mosi};
    if (s_cs_n) begin
      next_bit_cnt = 5'h00;
      next_miso = 1'b0;
    end else if (sck_fall) begin
      next_shift_in = wr_data;
      if (bit_cnt != 5'h1f) next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == SPI_CMD_LAST) begin
        next_cmd = wr_data;
        next_shift_out = reg_read(wr_data[6:0], user_led, refclk_source_select, state, latched_good);
      end
      spi_wr = (bit_cnt == SPI_DATA_LAST) && !cmd[7];
    end else if (sck_rise) begin
      next_miso = shift_out[7];
      next_shift_out = {shift_out[6:0], 1'b0};
    end
    next_user_led = (spi_wr && (cmd[6:0] == REG_USER_LED)) ? wr_data[3:0] : user_led;
    next_refsel = refclk_source_select;
    if ((state == ST_IDLE) && (next_state == ST_EN5))
      next_refsel = s_pcie_en ? s_refsw : REFCLK_SEL_RST;
    else if (spi_wr && (cmd[6:0] == REG_REFCLK_SEL))
      next_refsel = wr_data[0];
    // below ST_ON the display follows the state, so a stalled step leaves it frozen
    if (next_state < ST_ON)
      next_debug_led = next_state;
    else if (next_state == ST_FAIL)
      next_debug_led = next_flash_on ?
        {next_pair_idx, next_latched_good[{next_pair_idx, 1'b1}], next_latched_good[{next_pair_idx, 1'b0}]} :
        4'h0;
    else
      next_debug_led = next_user_led;
    next_refclk_oe = (next_state >= ST_RSTREL) && (next_state != ST_FAIL) &&
                     (refclk_buffer_oe | (s_lk23 & s_lk1));
    next_sync_cnt = (free_cnt == P_SYNC_MATCH) ? SYNC_PULSE_CYC :
                    (sync_cnt != 6'h00) ? sync_cnt - 6'h01 : 6'h00;
    next_pps_cnt = !s_pps ? 11'h000 : (pps_cnt == PPS_STABLE_CYC) ? pps_cnt : pps_cnt + 11'h001;
  end

  // sequencer and bookkeeping registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      state <= ST_IDLE;
      seen <= 1'b0;
      status_prev <= 1'b0;
      strap_drv <= 1'b0;
      latched_good <= 8'h00;
      flash_on <= 1'b0;
      pair_idx <= 2'h0;
      user_led <= USER_LED_RST;
      sck_prev <= 1'b0;
      bit_cnt <= 5'h00;
      shift_in <= 8'h00;
      cmd <= 8'h00;
      shift_out <= 8'h00;
      free_cnt <= 32'h0000_0000;
      sync_cnt <= 6'h00;
      pps_cnt <= 11'h000;
    end else begin
      sync1 <= {boot_strap_switches, aux_rail_good, five_volt_good, two_five_volt_good, core_supply_good_a,
                core_supply_good_b, core_supply_good_both, one_eight_volt_good, one_five_volt_good,
                point75_volt_good, clkgen23_locked, clkgen1_locked, proc_reset_status_n, pcie_enable_switch,
                refclk_default_switch, pps_in, spi_sck, spi_cs_n, spi_mosi};
      sync2 <= sync1;
      state <= next_state;
      seen <= next_seen;
      status_prev <= s_status_n;
      strap_drv <= next_strap_drv;
      latched_good <= next_latched_good;
      flash_on <= next_flash_on;
      pair_idx <= next_pair_idx;
      user_led <= next_user_led;
      sck_prev <= s_sck;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      cmd <= next_cmd;
      shift_out <= next_shift_out;
      free_cnt <= free_cnt + 32'h0000_0001;
      sync_cnt <= next_sync_cnt;
      pps_cnt <= next_pps_cnt;
    end
  end

  // pin outputs; the state-driven ones are decoded from the next state so they move on the same edge as the state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      five_volt_enable <= 1'b0;
      two_five_volt_enable <= 1'b0;
      core_supply_enable_a <= 1'b0;
      core_supply_enable_b <= 1'b0;
      one_eight_volt_enable <= 1'b0;
      one_five_volt_enable <= 1'b0;
      point75_volt_enable <= 1'b0;
      level_shift_oe_n <= 1'b1;
      clkgen23_init <= 1'b0;
      clkgen1_init <= 1'b0;
      clkgen_power_down_n <= 1'b1;
      refclk_init <= 1'b0;
      refclk_buffer_oe <= 1'b0;
      refclk_source_select <= REFCLK_SEL_RST;
      proc_reset_n <= 1'b0;
      proc_local_reset_n <= 1'b0;
      proc_power_on_reset_n <= 1'b0;
      proc_full_reset_n <= 1'b0;
      boot_strap_out <= '0;
      boot_strap_oe_n <= '1;
      proc_timer_in0_out <= 1'b0;
      proc_timer_in0_oe_n <= 1'b1;
      proc_timer_in1_out <= 1'b0;
      proc_timer_in1_oe_n <= 1'b1;
      rx_bandwidth_select <= 1'b0;
      power_good_led <= 1'b0;
      debug_led <= 4'h0;
      spi_miso <= 1'b0;
      proc_sync_pulse <= 1'b0;
      pps_forward_irq <= 1'b0;
    end else begin
      // 5V powers board logic too, so it stays on in failure
      five_volt_enable <= (next_state != ST_IDLE);
      two_five_volt_enable <= (next_state >= ST_EN25) && (next_state != ST_FAIL);
      core_supply_enable_a <= (next_state >= ST_CORE) && (next_state != ST_FAIL);
      core_supply_enable_b <= (next_state >= ST_CORE) && (next_state != ST_FAIL);
      one_eight_volt_enable <= (next_state >= ST_V18) && (next_state != ST_FAIL);
      clkgen23_init <= (next_state >= ST_CLK23) && (next_state != ST_FAIL);
      clkgen1_init <= (next_state >= ST_CLK1) && (next_state != ST_FAIL);
      one_five_volt_enable <= (next_state >= ST_V15) && (next_state != ST_FAIL);
      point75_volt_enable <= (next_state >= ST_V075) && (next_state != ST_FAIL);
      level_shift_oe_n <= !((next_state >= ST_V075) && (next_state != ST_FAIL));
      refclk_init <= (next_state >= ST_V075) && (next_state != ST_FAIL);
      clkgen_power_down_n <= (next_state != ST_FAIL);
      refclk_buffer_oe <= next_refclk_oe;
      refclk_source_select <= next_refsel;
      proc_reset_n <= (next_state >= ST_RSTREL) && (next_state != ST_FAIL);
      proc_local_reset_n <= (next_state >= ST_RSTREL) && (next_state != ST_FAIL);
      proc_power_on_reset_n <= (next_state >= ST_PORREL) && (next_state <= ST_ON);
      proc_full_reset_n <= (next_state >= ST_FULLREL) && (next_state != ST_FAIL);
      boot_strap_out <= s_strap;
      boot_strap_oe_n <= {STRAP_W{!next_strap_drv}};
      proc_timer_in0_out <= s_pcie_en;
      proc_timer_in0_oe_n <= (next_state == ST_ON);
      proc_timer_in1_out <= 1'b0;
      proc_timer_in1_oe_n <= 1'b1;
      rx_bandwidth_select <= 1'b0;
      power_good_led <= (next_state == ST_ON);
      debug_led <= next_debug_led;
      spi_miso <= next_miso;
      proc_sync_pulse <= (next_sync_cnt != 6'h00);
      pps_forward_irq <= s_pps && (next_pps_cnt == PPS_STABLE_CYC);
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_idle_until_aux: assert property ((state == ST_IDLE) && !s_aux |=> state == ST_IDLE)
    else $error("sequencer left idle without aux good");
  a_two_five_order: assert property ($rose(two_five_volt_enable) |-> five_volt_enable && $past(timer_done))
    else $error("2.5V enabled before 5V wait ended");
  a_core_together: assert property ($rose(core_supply_enable_a) |-> $rose(core_supply_enable_b) && two_five_volt_enable)
    else $error("core supplies not enabled together");
  a_one_eight_order: assert property ($rose(one_eight_volt_enable) |-> core_supply_enable_a && $past(s_ca && s_cb || seen))
    else $error("1.8V enabled before core goods");
  a_gen_one_order: assert property ($rose(clkgen1_init) |-> clkgen23_init && !one_five_volt_enable ##1 !one_five_volt_enable)
    else $error("generator one init order wrong");
  a_p75_group: assert property (point75_volt_enable |-> !level_shift_oe_n && refclk_init && one_five_volt_enable)
    else $error("0.75V group out of step");
  a_reset_release: assert property ($rose(proc_reset_n) |-> proc_local_reset_n && !proc_power_on_reset_n && !proc_full_reset_n)
    else $error("reset released with por or full not held");
  a_refclk_oe_gate: assert property ($rose(refclk_buffer_oe) |-> proc_reset_n && proc_local_reset_n && $past(s_lk23 && s_lk1))
    else $error("refclk oe before resets released and lock");
  a_por_then_full: assert property ($rose(proc_full_reset_n) |-> proc_power_on_reset_n && $past(proc_power_on_reset_n))
    else $error("full reset released before power-on reset");
  a_good_led_on: assert property (power_good_led |-> state == ST_ON && proc_full_reset_n)
    else $error("power good led outside on state");
  a_fail_por_now: assert property ((state == ST_ON) && rail_fail |=> !proc_power_on_reset_n && proc_reset_n && !power_good_led)
    else $error("power-on reset not asserted at failure");
  a_sync_width: assert property ($rose(proc_sync_pulse) |-> proc_sync_pulse[*8] ##38 proc_sync_pulse ##1 !proc_sync_pulse)
    else $error("sync pulse width wrong");
  a_timer_float: assert property ((state == ST_ON) |-> proc_timer_in0_oe_n && proc_timer_in1_oe_n)
    else $error("timer pins driven at runtime");
  a_rx_bw_low: assert property (!rx_bandwidth_select)
    else $error("rx bandwidth select not low");

  c_reach_on: cover property (state == ST_FULLREL ##1 state == ST_ON);
  c_reach_fail: cover property (state == ST_FWAIT ##1 state == ST_FAIL);
  c_spi_write: cover property (spi_wr && (cmd[6:0] == REG_USER_LED));
  c_sync_pulse: cover property ($rose(proc_sync_pulse));
endmodule
`default_nettype wire

/* File: bprs_board_model.sv */
// board supply, pll lock and processor status model for the sequencer bench
`timescale 1ns/10ps
`default_nettype none
module bprs_board_model (
  input wire logic sys_clk,
  input wire logic [6:0] rail_en,
  input wire logic pll_init,
  input wire logic full_n,
  input wire logic fail_0p75,
  output logic [6:0] rail_good,
  output logic pll_lock,
  output logic stat_n
);
  // rails report good one cycle after enable; a forced fault drops only the 0.75V rail
  always_ff @(posedge sys_clk) begin
    rail_good <= rail_en & {~fail_0p75, 6'h3f};
    pll_lock <= pll_init;
    stat_n <= full_n; // status lags the full reset release by a cycle
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the board power and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bprs_pkg::*;
  logic sys_clk = 0, rstn = 0, aux = 0, kill = 0, sck = 0, cs_n = 1, mosi = 0, pcie_sw = 0, ref_sw = 0;
  logic [6:0] en, good;
  logic [16:0] straps = 0, s_out, s_oe_n;
  logic [7:0] w, rd;
  logic lk1 = 0, pps = 0;
  logic [3:0] dled, v;
  logic lock, stat_n, miso, l_oe_n, c23, c1, pd_n, rinit, r_oe, rsel, rst_n, lrst_n, por_n, full_n;
  logic t0, t0_oe_n, t1, t1_oe_n, rxbw, pg_led, sync, irq;
  int fails = 0, check_count = 0, seed = 32'h1ca9, n, sw = 0;
  always #4 sys_clk = ~sys_clk;
  assign w = {pg_led, full_n, por_n, rst_n, en[4], en[2], en[1], en[0]};
  // short waits keep the whole power-up within a few hundred cycles
  bprs_top #(.P_WAIT_LONG(32'd40), .P_WAIT_RAIL(32'd20), .P_WAIT_CLK(32'd10), .P_FLASH(32'd16),
    .P_SYNC_MATCH(32'd100)) DUT (.sys_clk(sys_clk), .rstn(rstn), .aux_rail_good(aux),
    .five_volt_good(good[0]), .two_five_volt_good(good[1]), .core_supply_good_a(good[2]),
    .core_supply_good_b(good[3]), .core_supply_good_both(good[2] & good[3]), .one_eight_volt_good(good[4]),
    .one_five_volt_good(good[5]), .point75_volt_good(good[6]), .clkgen23_locked(lock), .clkgen1_locked(lk1),
    .proc_reset_status_n(stat_n), .boot_strap_switches(straps), .pcie_enable_switch(pcie_sw),
    .refclk_default_switch(ref_sw), .pps_in(pps), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .five_volt_enable(en[0]), .two_five_volt_enable(en[1]), .core_supply_enable_a(en[2]),
    .core_supply_enable_b(en[3]), .one_eight_volt_enable(en[4]), .one_five_volt_enable(en[5]),
    .point75_volt_enable(en[6]), .level_shift_oe_n(l_oe_n), .clkgen23_init(c23), .clkgen1_init(c1),
    .clkgen_power_down_n(pd_n), .refclk_init(rinit), .refclk_buffer_oe(r_oe), .refclk_source_select(rsel),
    .proc_reset_n(rst_n), .proc_local_reset_n(lrst_n), .proc_power_on_reset_n(por_n),
    .proc_full_reset_n(full_n), .boot_strap_out(s_out), .boot_strap_oe_n(s_oe_n), .proc_timer_in0_out(t0),
    .proc_timer_in0_oe_n(t0_oe_n), .proc_timer_in1_out(t1), .proc_timer_in1_oe_n(t1_oe_n),
    .rx_bandwidth_select(rxbw), .power_good_led(pg_led), .debug_led(dled), .proc_sync_pulse(sync),
    .pps_forward_irq(irq));
  bprs_board_model M (.sys_clk(sys_clk), .rail_en(en), .pll_init(c23), .full_n(full_n), .fail_0p75(kill),
    .rail_good(good), .pll_lock(lock), .stat_n(stat_n));
  always @(posedge sys_clk) if (sync === 1'b1) sw++;
  task tick;
    @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // count cycles until watched output k goes high, bounded
  task automatic wt(input int k);
    n = 0;
    while (w[k] !== 1'b1 && n < 400) begin
      tick;
      n++;
    end
  endtask
  // spi write frame, msb first, sampled on falling sck
  task automatic spi_wr(input logic [15:0] f, output logic [7:0] r);
    r = 8'h00;
    cs_n = 0;
    repeat (6) tick;
    for (int i = 15; i >= 0; i--) begin
      mosi = f[i];
      sck = 1;
      repeat (5) tick;
      r = {r[6:0], miso}; // master takes miso as sck falls; last 8 bits are the data byte
      sck = 0;
      repeat (5) tick;
    end
    cs_n = 1;
    repeat (8) tick;
  endtask
  task report_and_stop;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    straps = 17'($random(seed));
    pcie_sw = 1'($random(seed));
    ref_sw = 1'($random(seed));
    repeat (16) tick;
    rstn = 1;
    repeat (30) tick;
    chk(en[0], 0);
    aux = 1;
    wt(0);
    wt(1);
    chk(32'(n >= 40 && n <= 44), 1);
    wt(2);
    chk(32'(n >= 20 && n <= 28), 1);
    chk(en[3], 1);
    wt(3);
    chk(32'(n >= 20 && n <= 28), 1);
    wt(4);
    chk({s_out, s_oe_n, l_oe_n, c23, c1, rinit}, {straps, 17'h0, 4'h7});
    chk({t0, t0_oe_n, lrst_n, por_n, full_n}, {pcie_sw, 4'h4});
    chk({r_oe, dled}, {1'b0, ST_RSTREL});
    // generator one locks late, so the buffer enable must wait for it
    lk1 = 1;
    wt(5);
    chk(32'(n >= 20 && n <= 24), 1);
    wt(6);
    chk(32'(n >= 20 && n <= 24), 1);
    wt(7);
    chk(32'(n <= 8), 1);
    chk({s_oe_n, t0_oe_n, t1_oe_n, r_oe, dled}, {17'h1_ffff, 3'h7, 4'h0});
    chk(rsel, pcie_sw ? ref_sw : 1'b0);
    repeat (4) begin
      v = 4'($random(seed));
      spi_wr({12'h080, v}, rd);
      chk(dled, v);
    end
    spi_wr(16'h300a, rd);
    chk(dled, v);
    spi_wr(16'h8800, rd);
    chk(rd, {4'h0, v});
    spi_wr(16'h8a00, rd);
    chk(rd, {4'h0, ST_ON});
    spi_wr(16'h0901, rd);
    chk(rsel, 1'b1);
    spi_wr(16'h8900, rd);
    chk(rd, 8'h01);
    // one long pps pulse must not pass before the stable time and must pass after it
    pps = 1;
    repeat (200) tick;
    chk(irq, 0);
    repeat (1150) tick;
    chk(irq, 1);
    pps = 0;
    repeat (5) tick;
    chk({irq, t1, t1_oe_n}, 3'h1);
    kill = 1;
    repeat (6) tick;
    chk({por_n, en[2]}, 2'h1);
    repeat (30) tick;
    chk({en[6:2], pg_led, pd_n, rst_n, full_n, en[0]}, 10'h1);
    // every rail was good before the fault, so each flashed pair shows both bits set
    for (int p = 0; p < 4; p++) begin
      n = 0;
      while (dled === 4'h0 && n < 60) begin
        tick;
        n++;
      end
      chk(dled, {2'(p), 2'h3});
      while (dled !== 4'h0 && n < 60) begin
        tick;
        n++;
      end
    end
    spi_wr(16'h8b00, rd);
    chk(rd, 8'hff);
    chk({rxbw, sw[7:0]}, 9'd46);
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    report_and_stop;
  end
endmodule
`default_nettype wire
